// >>> hdl/drive_enable_ready_interlock.sv
// enable gating, readiness interlock and register slave of the drive controller
// assumes one core clock, synchronous active-low reset, Avalon-MM master
//
// Functional notes
// - run enable inactive: drive locked, no PWM pulses.
// - rotating field enable inactive: field blocked on a separate path.
// - both enables fixed; four remaining digital inputs assignable by configuration.
// - readiness shows as bit 14 of status register 0x40, one when ready.
// - any fault opens ready relay contact and clears readiness bit.
// - not ready: contact open, fault lamp and segment code; ready: closed.
// - config 0x5A bit 5: one ignores missing power, zero withholds readiness.
// - precharge mode: first output on while DC link exceeds user variable one.
// - auxiliary supply undervoltage raises hardware error 1, withdrawing readiness.
`timescale 1ns/1ps
`default_nettype none
module drive_enable_ready_interlock
	import interlock_pkg::*;
#(
	parameter int SELF_CHECK_CYCLES = SELF_CHECK_CYC,
	parameter int DC_W = 16
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire drive_inputs_t pins_i,
	input wire logic power_voltage_ok_i,
	input wire logic aux_undervoltage_i,
	input wire logic fault_i,
	input wire logic [DC_W-1:0] dc_link_voltage_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output var drive_outputs_t drive_o,
	output logic irq_o
);
	initial begin
		if (DC_W < 1 || DC_W > 16) begin
			$error("dc link width must be 1 to 16");
		end
		if (SELF_CHECK_CYCLES < 1) begin
			$error("self-check must last at least one cycle");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisation and routing
	logic [5:0] pins_sync;
	logic [3:0] func_lines;
	logic run_s;
	logic field_s;
	logic [31:0] config_reg;
	input_sync #(.WIDTH(6)) u_sync (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.async_i(pins_i),
		.sync_o(pins_sync)
	);
	assign run_s = pins_sync[5];
	assign field_s = pins_sync[4];
	input_router #(.N(4)) u_router (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.prog_i(pins_sync[3:0]),
		.route_i(config_reg[CFG_ROUTE_LSB +: 8]),
		.func_o(func_lines)
	);

	////////////////////////////////////////////////////////////////////////
	// registers written by software
	logic [15:0] user_var_one;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_status;
	logic fault_clear;
	logic bus_pending;
	logic bus_write;
	logic bus_read;
	logic [31:0] wmask;
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	// one wait cycle per access: the first cycle raises waitrequest, the second completes
	assign bus_write = avs_write_i && bus_pending;
	assign bus_read = avs_read_i && bus_pending;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			bus_pending <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && !bus_pending) begin
			bus_pending <= 1'b1;
			avs_waitrequest_o <= 1'b0;
		end else begin
			bus_pending <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end
	end
	// config, user variable, interrupt enable, fault clear strobe
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			config_reg <= CONFIG_RESET;
			user_var_one <= USER_VAR_ONE_RESET;
			irq_enable <= '0;
			fault_clear <= 1'b0;
		end else begin
			fault_clear <= 1'b0;
			if (bus_write) begin
				if (avs_address_i == ADDR_CONFIG) begin
					config_reg <= (config_reg & ~wmask) | (avs_writedata_i & wmask);
				end else if (avs_address_i == ADDR_USER_VAR_ONE) begin
					user_var_one <= (user_var_one & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
				end else if (avs_address_i == ADDR_IRQ_ENABLE) begin
					irq_enable <= avs_writedata_i[IRQ_W-1:0];
				end else if (avs_address_i == ADDR_FAULT_CTRL) begin
					fault_clear <= avs_writedata_i[0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// self-check counter after reset
	logic [$clog2(SELF_CHECK_CYCLES+1)-1:0] check_cnt;
	logic check_done;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			check_cnt <= '0;
			check_done <= 1'b0;
		end else if (!check_done) begin
			if (check_cnt == $bits(check_cnt)'(SELF_CHECK_CYCLES - 1)) begin
				check_done <= 1'b1;
			end
			check_cnt <= check_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readiness state machine
	ready_state_t state;
	ready_state_t next_state;
	logic power_fault;
	logic power_missing;
	logic ready;
	logic [7:0] hw_error;
	// undervoltage is latched as hardware error 1 until cleared
	assign power_missing = !power_voltage_ok_i && !config_reg[CFG_READY_NEEDS_POWER_BIT];
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			power_fault <= 1'b0;
			hw_error <= 8'h00;
		end else if (aux_undervoltage_i) begin
			power_fault <= 1'b1;
			hw_error <= 8'(HW_ERROR_POWER);
		end else if (fault_clear) begin
			power_fault <= 1'b0;
			hw_error <= 8'h00;
		end
	end
	always_comb begin
		next_state = state;
		case (state)
			ST_SELF_CHECK: begin
				if (check_done) begin
					next_state = ST_NOT_READY;
				end
			end
			ST_NOT_READY: begin
				if (fault_i || power_fault || aux_undervoltage_i) begin
					next_state = ST_FAULT;
				end else if (!power_missing) begin
					next_state = ST_READY;
				end
			end
			ST_READY: begin
				if (fault_i || power_fault || aux_undervoltage_i) begin
					next_state = ST_FAULT;
				end else if (power_missing) begin
					next_state = ST_NOT_READY;
				end
			end
			ST_FAULT: begin
				if (fault_clear && !fault_i && !aux_undervoltage_i) begin
					next_state = ST_NOT_READY;
				end
			end
			default: next_state = ST_FAULT;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state <= ST_SELF_CHECK;
		end else begin
			state <= next_state;
		end
	end
	assign ready = (state == ST_READY);

	////////////////////////////////////////////////////////////////////////
	// drive outputs, all registered
	logic pwm_allowed;
	assign pwm_allowed = run_s && field_s && ready;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			// not ready from reset on, so lamp lit and error code shown at once
			drive_o <= '{fault_lamp: 1'b1, segment_code: 8'hE0, default: 1'b0};
		end else begin
			drive_o.pwm_enable <= pwm_allowed;
			drive_o.field_enable <= field_s && ready;
			drive_o.ready_relay_contact <= ready;
			drive_o.fault_lamp <= !ready;
			// segment shows hardware error code, or 0xE0 when otherwise not ready
			drive_o.segment_code <= ready ? 8'h00 : ((hw_error != 8'h00) ? hw_error : 8'hE0);
			drive_o.prog_output_one <= config_reg[CFG_PRECHARGE_BIT] &&
				(16'(dc_link_voltage_i) > user_var_one);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: set wins over clear
	logic ready_q;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_clear;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= ready;
		end
	end
	assign irq_events[IRQ_FAULT] = (next_state == ST_FAULT) && (state != ST_FAULT);
	assign irq_events[IRQ_READY_RISE] = ready && !ready_q;
	assign irq_events[IRQ_READY_FALL] = !ready && ready_q;
	assign irq_events[IRQ_POWER_FAULT] = aux_undervoltage_i && !power_fault;
	assign irq_clear = (bus_write && avs_address_i == ADDR_IRQ_CLEAR) ?
		avs_writedata_i[IRQ_W-1:0] : '0;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			irq_status <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
			irq_o <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[STAT_READY_BIT] = ready;
		status_word[STAT_PWM_BIT] = drive_o.pwm_enable;
		status_word[STAT_FIELD_BIT] = drive_o.field_enable;
		status_word[STAT_FAULT_BIT] = (state == ST_FAULT);
		status_word[STAT_POWER_FAULT_BIT] = power_fault;
		status_word[STAT_INPUTS_LSB +: 4] = func_lines;
		status_word[STAT_INPUTS_LSB+4 +: 2] = {run_s, field_s};
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avs_readdata_o <= '0;
		end else if (avs_read_i && !bus_pending) begin
			if (avs_address_i == ADDR_STATUS) begin
				avs_readdata_o <= status_word;
			end else if (avs_address_i == ADDR_CONFIG) begin
				avs_readdata_o <= config_reg;
			end else if (avs_address_i == ADDR_USER_VAR_ONE) begin
				avs_readdata_o <= {16'h0000, user_var_one};
			end else if (avs_address_i == ADDR_DC_LINK) begin
				avs_readdata_o <= 32'(dc_link_voltage_i);
			end else if (avs_address_i == ADDR_IRQ_STATUS) begin
				avs_readdata_o <= 32'(irq_status);
			end else if (avs_address_i == ADDR_IRQ_ENABLE) begin
				avs_readdata_o <= 32'(irq_enable);
			end else if (avs_address_i == ADDR_FAULT_CTRL) begin
				avs_readdata_o <= {24'h000000, hw_error};
			end else begin
				avs_readdata_o <= UNMAPPED_READ;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	a_pwm_needs_run: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!run_s |=> !drive_o.pwm_enable) else $error("pwm active without run enable");
	a_field_block: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!field_s |=> !drive_o.field_enable && !drive_o.pwm_enable)
		else $error("field not blocked");
	a_pwm_both: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		drive_o.pwm_enable |-> $past(run_s) && $past(field_s))
		else $error("pwm without both enables");
	a_ready_bit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		avs_read_i && !bus_pending && avs_address_i == ADDR_STATUS |=>
		avs_readdata_o[STAT_READY_BIT] == $past(ready)) else $error("ready bit wrong");
	a_fault_opens: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_i && state == ST_READY |=> !ready ##1 !drive_o.ready_relay_contact)
		else $error("fault did not open contact");
	a_relay_lamp: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		drive_o.ready_relay_contact != drive_o.fault_lamp)
		else $error("lamp and contact disagree");
	a_power_sel: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state == ST_READY && !power_voltage_ok_i && !config_reg[CFG_READY_NEEDS_POWER_BIT]
		&& !fault_i && !power_fault && !aux_undervoltage_i |=> state == ST_NOT_READY)
		else $error("missing power kept ready");
	a_precharge: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		config_reg[CFG_PRECHARGE_BIT] && (16'(dc_link_voltage_i) > user_var_one) |=>
		drive_o.prog_output_one) else $error("precharge output missing");
	a_undervolt_err: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		aux_undervoltage_i |=> hw_error == 8'h01 && power_fault ##1 !ready)
		else $error("undervoltage not flagged");
	a_reset_safe: assert property (@(posedge core_clk_i)
		$rose(reset_n_i) |-> !drive_o.pwm_enable && !drive_o.ready_relay_contact
		&& state == ST_SELF_CHECK) else $error("unsafe after reset");
	// waitrequest drops for one cycle only; read data must not move at completion
	a_wait_one_cycle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_bus_answer: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o && !bus_pending |=> !avs_waitrequest_o)
		else $error("bus request not answered");
	a_read_stands: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		bus_read |=> $stable(avs_readdata_o))
		else $error("read data moved after completion");
	// interrupt status: a new event always lands, even against a clear in the same cycle
	a_irq_set_wins: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		|irq_events |=> (irq_status & $past(irq_events)) == $past(irq_events))
		else $error("interrupt event lost");
	a_irq_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		irq_o == |(irq_status & $past(irq_enable)))
		else $error("interrupt level wrong");
	// readiness gates the pwm and field enables one edge later
	a_not_ready_blocks: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!ready |=> !drive_o.pwm_enable && !drive_o.field_enable)
		else $error("drive active while not ready");
	a_self_check_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!check_done |-> state == ST_SELF_CHECK && !drive_o.ready_relay_contact)
		else $error("ready before self-check");
	a_segment_error: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!drive_o.ready_relay_contact |-> drive_o.fault_lamp && drive_o.segment_code != 8'h00)
		else $error("no error indication");
endmodule
`default_nettype wire

// >>> hdl/interlock_pkg.sv
// constants, types and register map of the drive enable and readiness interlock
// assumes a single 200 MHz core clock and an Avalon-MM register bus with 32-bit data
package interlock_pkg;
	localparam int CLK_MHZ = 200;
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h40;
	localparam logic [7:0] ADDR_CONFIG = 8'h5A;
	localparam logic [7:0] ADDR_USER_VAR_ONE = 8'h10;
	localparam logic [7:0] ADDR_DC_LINK = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
	localparam logic [7:0] ADDR_FAULT_CTRL = 8'h2C;
	// status field positions
	localparam int STAT_READY_BIT = 14;
	localparam int STAT_PWM_BIT = 0;
	localparam int STAT_FIELD_BIT = 1;
	localparam int STAT_FAULT_BIT = 2;
	localparam int STAT_POWER_FAULT_BIT = 3;
	localparam int STAT_INPUTS_LSB = 4;
	// config field positions
	localparam int CFG_READY_NEEDS_POWER_BIT = 5;
	localparam int CFG_PRECHARGE_BIT = 0;
	localparam int CFG_ROUTE_LSB = 8;
	// reset values
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [15:0] USER_VAR_ONE_RESET = 16'h6590;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// interrupt events
	localparam int IRQ_W = 4;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_READY_RISE = 1;
	localparam int IRQ_READY_FALL = 2;
	localparam int IRQ_POWER_FAULT = 3;
	// self-check duration
	localparam int SELF_CHECK_US = 10;
	localparam int SELF_CHECK_CYC = SELF_CHECK_US * CLK_MHZ;
	localparam int HW_ERROR_POWER = 1;
	typedef enum logic [1:0] {
		ST_SELF_CHECK = 2'b00,
		ST_NOT_READY = 2'b01,
		ST_READY = 2'b10,
		ST_FAULT = 2'b11
	} ready_state_t;
	typedef struct packed {
		logic run_enable_in;
		logic rotating_field_enable_in;
		logic limit_input_one;
		logic limit_input_two;
		logic prog_input_one;
		logic prog_input_two;
	} drive_inputs_t;
	typedef struct packed {
		logic pwm_enable;
		logic field_enable;
		logic ready_relay_contact;
		logic fault_lamp;
		logic [7:0] segment_code;
		logic prog_output_one;
	} drive_outputs_t;
endpackage

// >>> hdl/input_sync.sv
// two-flop synchroniser for a bus of levels
// assumes inputs are levels that change slowly against the core clock
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter int WIDTH = 6
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	initial begin
		if (WIDTH < 1) begin
			$error("input_sync width must be at least one");
		end
	end
	////////////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/input_router.sv
// routes the four programmable inputs onto function lines by a 2-bit selector each
// assumes synchronised inputs; output is registered
`timescale 1ns/1ps
`default_nettype none
module input_router #(
	parameter int N = 4
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [N-1:0] prog_i,
	input wire logic [2*N-1:0] route_i,
	output logic [N-1:0] func_o
);
	logic [N-1:0] next_func;
	initial begin
		if (N != 4) begin
			$error("input_router serves exactly four programmable inputs");
		end
	end
	////////////////////////////////////////////////////////////////////////
	// each function line takes the input its selector names
	always_comb begin
		next_func = '0;
		for (int f = 0; f < N; f++) begin
			next_func[f] = prog_i[route_i[2*f +: 2]];
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			func_o <= '0;
		end else begin
			func_o <= next_func;
		end
	end
endmodule
`default_nettype wire

// >>> bench/vcu_model.sv
// vehicle control unit model: drives the enable pins, the programmable inputs and power
// assumes the bench changes its requests just after a rising edge of core_clk_i
`timescale 1ns/1ps
`default_nettype none
module vcu_model
	import interlock_pkg::*;
#(
	parameter int FIELD_LEAD = 16
) (
	input wire logic core_clk_i,
	input wire logic field_req_i,
	input wire logic run_req_i,
	input wire logic power_req_i,
	input wire logic [3:0] prog_req_i,
	output var drive_inputs_t pins_o,
	output logic power_ok_o
);
	int lead = 0;
	////////////////////////////////////////////////////////////////////////////
	// field lead counter, restarts whenever the field enable drops
	always_ff @(posedge core_clk_i) begin
		if (!field_req_i) begin
			lead <= 0;
		end else if (lead < FIELD_LEAD) begin
			lead <= lead + 1;
		end
	end
	// run held back until field has led long enough and power is present
	assign pins_o.run_enable_in = run_req_i && field_req_i && power_req_i && lead >= FIELD_LEAD;
	assign pins_o.rotating_field_enable_in = field_req_i;
	// limit lines wired as limit switches, plain levels otherwise
	assign pins_o.limit_input_one = prog_req_i[3];
	assign pins_o.limit_input_two = prog_req_i[2];
	assign pins_o.prog_input_one = prog_req_i[1];
	assign pins_o.prog_input_two = prog_req_i[0];
	assign power_ok_o = power_req_i;
endmodule
`default_nettype wire

// >>> bench/drive_enable_ready_interlock_bench.sv
// self-checking bench for the enable and readiness interlock
// assumes the vehicle control model in vcu_model.sv and a shortened self-check
`timescale 1ns/1ps
`default_nettype none
module drive_enable_ready_interlock_bench;
	import interlock_pkg::*;
	localparam int CHECK_CYC = 4;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic field_req = 1'b0, run_req = 1'b0, power_req = 1'b1;
	logic [3:0] prog_req = 4'h0;
	logic aux_uv = 1'b0, fault = 1'b0;
	logic [15:0] dc_link = 16'h0000;
	logic [7:0] address = 8'h00;
	logic read = 1'b0, write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata, rd;
	logic waitrequest, irq, power_ok;
	drive_inputs_t pins;
	drive_outputs_t drive;
	int fails = 0, checks_done = 0;
	////////////////////////////////////////////////////////////////////////////
	// 200 MHz core clock
	always #2.5 core_clk_i = ~core_clk_i;
	vcu_model #(.FIELD_LEAD(16)) vcu (.core_clk_i(core_clk_i), .field_req_i(field_req),
		.run_req_i(run_req), .power_req_i(power_req), .prog_req_i(prog_req),
		.pins_o(pins), .power_ok_o(power_ok));
	drive_enable_ready_interlock #(.SELF_CHECK_CYCLES(CHECK_CYC), .DC_W(16)) dut (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .pins_i(pins),
		.power_voltage_ok_i(power_ok), .aux_undervoltage_i(aux_uv), .fault_i(fault),
		.dc_link_voltage_i(dc_link), .avs_address_i(address), .avs_read_i(read),
		.avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest), .drive_o(drive),
		.irq_o(irq));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// one Avalon-MM transfer, request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		@(posedge core_clk_i);
		while (waitrequest !== 1'b0 && n < 40) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n == 40) fails++;
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(rd & mask, exp);
	endtask
	// bounded wait for one output bit of drive_o
	task automatic wait_out(input int idx, input logic v);
		int n;
		n = 0;
		while (drive[idx] !== v && n < 200) begin
			@(posedge core_clk_i);
			n++;
		end
		check(32'(drive[idx]), 32'(v));
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(32'(drive.pwm_enable), 32'h0);
		check(32'(drive.ready_relay_contact), 32'h0);
		check(32'(drive.fault_lamp), 32'h1);
		wait_out(10, 1'b1);
		check(32'(drive.segment_code), 32'h0);
		rdchk(ADDR_STATUS, 32'h0000_4000, 32'h0000_4000);
		rdchk(ADDR_CONFIG, 32'hFFFF_FFFF, CONFIG_RESET);
		rdchk(8'hFC, 32'hFFFF_FFFF, UNMAPPED_READ);
		$display("reset test done");
	endtask
	task automatic t_enable;
		field_req <= 1'b1;
		run_req <= 1'b1;
		tick(10);
		check(32'(drive.pwm_enable), 32'h0);
		wait_out(12, 1'b1);
		check(32'(drive.field_enable), 32'h1);
		run_req <= 1'b0;
		tick(3);
		check(32'(drive.pwm_enable), 32'h1);
		tick(1);
		check(32'(drive.pwm_enable), 32'h0);
		check(32'(drive.field_enable), 32'h1);
		run_req <= 1'b1;
		wait_out(12, 1'b1);
		field_req <= 1'b0;
		tick(4);
		check(32'(drive.field_enable), 32'h0);
		check(32'(drive.pwm_enable), 32'h0);
		run_req <= 1'b0;
		$display("enable test done");
	endtask
	task automatic t_fault;
		bus(1'b1, ADDR_IRQ_CLEAR, 32'h0000_000F);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
		check(32'(irq), 32'h0);
		fault <= 1'b1;
		wait_out(10, 1'b0);
		check(32'(drive.fault_lamp), 32'h1);
		check(32'(drive.segment_code), 32'hE0);
		rdchk(ADDR_STATUS, 32'h0000_4000, 32'h0);
		rdchk(ADDR_IRQ_STATUS, 32'h0000_0007, 32'h5);
		check(32'(irq), 32'h1);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0000);
		tick(2);
		check(32'(irq), 32'h0);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
		fault <= 1'b0;
		tick(2);
		check(32'(irq), 32'h1);
		bus(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0001);
		tick(2);
		check(32'(irq), 32'h0);
		check(32'(drive.ready_relay_contact), 32'h0);
		bus(1'b1, ADDR_FAULT_CTRL, 32'h0000_0001);
		wait_out(10, 1'b1);
		$display("fault test done");
	endtask
	task automatic t_power;
		power_req <= 1'b0;
		wait_out(10, 1'b0);
		bus(1'b1, ADDR_CONFIG, 32'h0000_0020);
		wait_out(10, 1'b1);
		bus(1'b1, ADDR_CONFIG, 32'h0000_0000);
		wait_out(10, 1'b0);
		power_req <= 1'b1;
		bus(1'b1, ADDR_FAULT_CTRL, 32'h0000_0001);
		wait_out(10, 1'b1);
		aux_uv <= 1'b1;
		wait_out(10, 1'b0);
		rdchk(ADDR_FAULT_CTRL, 32'hFFFF_FFFF, 32'(HW_ERROR_POWER));
		rdchk(ADDR_STATUS, 32'h0000_400C, 32'h0000_000C);
		rdchk(ADDR_IRQ_STATUS, 32'h0000_0008, 32'h8);
		check(32'(drive.segment_code), 32'(HW_ERROR_POWER));
		aux_uv <= 1'b0;
		bus(1'b1, ADDR_FAULT_CTRL, 32'h0000_0001);
		wait_out(10, 1'b1);
		$display("power test done");
	endtask
	task automatic t_precharge;
		rdchk(ADDR_USER_VAR_ONE, 32'h0000_FFFF, 32'(USER_VAR_ONE_RESET));
		dc_link <= USER_VAR_ONE_RESET;
		bus(1'b1, ADDR_CONFIG, 32'h0000_0001);
		tick(4);
		check(32'(drive.prog_output_one), 32'h0);
		dc_link <= USER_VAR_ONE_RESET + 16'h0001;
		wait_out(0, 1'b1);
		bus(1'b1, ADDR_USER_VAR_ONE, 32'h0000_6591);
		wait_out(0, 1'b0);
		rdchk(ADDR_DC_LINK, 32'h0000_FFFF, 32'h0000_6591);
		$display("precharge test done");
	endtask
	task automatic t_route;
		prog_req <= 4'hA;
		bus(1'b1, ADDR_CONFIG, 32'h0000_1B00);
		tick(4);
		rdchk(ADDR_STATUS, 32'h0000_02F0, 32'h0000_0050);
		bus(1'b1, ADDR_CONFIG, 32'h0000_E400);
		tick(4);
		rdchk(ADDR_STATUS, 32'h0000_02F0, 32'h0000_00A0);
		bus(1'b1, ADDR_STATUS, 32'h0000_0000);
		rdchk(ADDR_STATUS, 32'h0000_4000, 32'h0000_4000);
		$display("route test done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs a few hundred cycles
	initial begin
		tick(20000);
		fails++;
		test_done();
	end
	initial begin
		tick(12);
		reset_n_i <= 1'b1;
		tick(1);
		t_reset();
		t_enable();
		t_fault();
		t_power();
		t_precharge();
		t_route();
		test_done();
	end
endmodule
`default_nettype wire
